// ==== lane_map_pkg.sv ====
// Purpose: Shared constants for the sample-to-lane frame mapper
// Assumes: Samples arrive in 12-bit slots, value right-justified in the slot
// Notes: Format codes follow the link format selection values
package lane_map_pkg;
   localparam int NUM_LANES = 8;
   localparam int NUM_CHANNELS = 4;
   localparam int SAMPLES_PER_CHANNEL = 8;
   localparam int SAMPLE_SLOT_BITS = 12;
   localparam int CHANNEL_BUS_BITS = SAMPLES_PER_CHANNEL * SAMPLE_SLOT_BITS;
   localparam int MAX_OCTETS = 5;
   localparam int OCTET_BITS = 8;
   localparam int LANE_WORD_BITS = MAX_OCTETS * OCTET_BITS;
   localparam int OCTET_COUNT_BITS = 3;

   // Link format selection codes served here
   localparam logic [3:0] FMT_8B_4L_8B10B = 4'h2;
   localparam logic [3:0] FMT_10B_4L_8B10B = 4'h3;
   localparam logic [3:0] FMT_12B_3L_64B66B = 4'h4;
   localparam logic [3:0] FMT_8B_2L_64B66B = 4'h5;
   localparam logic [3:0] FMT_12B_6L_64B66B = 4'h6;
   localparam logic [3:0] FMT_8B_4L_64B66B = 4'h7;
   localparam logic [3:0] FMT_12B_4L_64B66B = 4'h8;
   localparam logic [3:0] FMT_8B_8L_8B10B = 4'h9;
   localparam logic [3:0] FMT_10B_8L_8B10B = 4'hA;

   // Reset values
   localparam logic [NUM_LANES-1:0] LANE_ENABLE_RESET = 8'h00;
   localparam logic [OCTET_COUNT_BITS-1:0] OCTETS_RESET = 3'h0;

   // Octets per lane per frame; zero marks an unserved format
   function automatic logic [OCTET_COUNT_BITS-1:0] frame_octets(input logic [3:0] fmt);
      case (fmt)
         FMT_8B_4L_8B10B, FMT_8B_4L_64B66B, FMT_8B_8L_8B10B: frame_octets = 3'h1;
         FMT_12B_3L_64B66B, FMT_8B_2L_64B66B, FMT_12B_6L_64B66B: frame_octets = 3'h2;
         FMT_12B_4L_64B66B: frame_octets = 3'h3;
         FMT_10B_4L_8B10B, FMT_10B_8L_8B10B: frame_octets = 3'h5;
         default: frame_octets = 3'h0;
      endcase
   endfunction

   // Lanes driven at the largest lane count of each format
   function automatic logic [3:0] frame_lanes(input logic [3:0] fmt);
      case (fmt)
         FMT_8B_2L_64B66B: frame_lanes = 4'h2;
         FMT_12B_3L_64B66B: frame_lanes = 4'h3;
         FMT_8B_4L_8B10B, FMT_10B_4L_8B10B, FMT_8B_4L_64B66B, FMT_12B_4L_64B66B: frame_lanes = 4'h4;
         FMT_12B_6L_64B66B: frame_lanes = 4'h6;
         FMT_8B_8L_8B10B, FMT_10B_8L_8B10B: frame_lanes = 4'h8;
         default: frame_lanes = 4'h0;
      endcase
   endfunction
endpackage

// ==== lane_octet_shifter.sv ====
// Purpose: Holds one lane's frame word and presents it an octet at a time
// Assumes: Word is MSB-aligned, first octet in the top bits
// Notes: Zeros shift in from below, so stale bits never reach the lane
`timescale 1ns/100ps
module lane_octet_shifter #(
   parameter int WORD_BITS = 40
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic load,
   input wire logic shift,
   input wire logic [WORD_BITS-1:0] word_in,
   output logic [7:0] octet_out
);
   logic [WORD_BITS-1:0] word;

   if (WORD_BITS % 8 != 0 || WORD_BITS < 8) begin : g_bad_width
      $error("lane_octet_shifter: WORD_BITS must be a whole number of octets");
   end

   // Load wins over shift so a back-to-back frame starts cleanly
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         word <= '0;
      end else if (load) begin
         word <= word_in;
      end else if (shift) begin
         word <= word << 8;
      end
   end

   assign octet_out = word[WORD_BITS-1 -: 8];
endmodule // lane_octet_shifter

// ==== adc_lane_frame_mapper.sv ====
// Purpose: Maps four channels of converter samples into per-lane octets for one frame
// Assumes: Sample inputs and format select come from logic on clk; samples valid with frame_valid
// Notes: Only the largest lane count of each format is served
//        Unserved codes take no frame and power every lane down
//        A select change mid-frame leaves the loaded frame intact
//        Lane words are MSB-aligned; the shifters drain them from the top
`timescale 1ns/100ps
module adc_lane_frame_mapper
   import lane_map_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] link_format_select,
   input wire logic frame_valid,
   input wire logic [CHANNEL_BUS_BITS-1:0] chan_a_samples,
   input wire logic [CHANNEL_BUS_BITS-1:0] chan_b_samples,
   input wire logic [CHANNEL_BUS_BITS-1:0] chan_c_samples,
   input wire logic [CHANNEL_BUS_BITS-1:0] chan_d_samples,
   output logic frame_ready,
   output logic format_supported,
   output logic [NUM_LANES-1:0] lane_enable,
   output logic octet_valid,
   output logic frame_start,
   output logic [OCTET_BITS*NUM_LANES-1:0] lane_octets
);
   logic [CHANNEL_BUS_BITS-1:0] chan [NUM_CHANNELS];
   logic [LANE_WORD_BITS-1:0] lane_word [NUM_LANES];
   logic [47:0] pack48;
   logic [OCTET_COUNT_BITS-1:0] remaining;
   logic [OCTET_COUNT_BITS-1:0] next_remaining;
   logic [OCTET_COUNT_BITS-1:0] sel_octets;
   logic accept;
   logic served;
   logic shift_on;
   logic [3:0] sel_lanes;

   // The layouts below are written for this geometry; refuse other lane, channel or word sizes, and fewer or narrower sample slots
   if (NUM_LANES != 8) begin : g_bad_lanes
      $error("adc_lane_frame_mapper: layouts are written for eight lanes");
   end
   if (NUM_CHANNELS != 4) begin : g_bad_channels
      $error("adc_lane_frame_mapper: layouts are written for four channels");
   end
   if (SAMPLE_SLOT_BITS < 12 || SAMPLES_PER_CHANNEL < 8) begin : g_bad_slots
      $error("adc_lane_frame_mapper: eight 12-bit sample slots per channel are needed");
   end
   if (OCTET_BITS != 8 || LANE_WORD_BITS != 40) begin : g_bad_word
      $error("adc_lane_frame_mapper: lane words must hold five 8-bit octets");
   end
   if (MAX_OCTETS >= (1 << OCTET_COUNT_BITS)) begin : g_bad_count
      $error("adc_lane_frame_mapper: octet counter too narrow for the longest frame");
   end

   assign chan[0] = chan_a_samples;
   assign chan[1] = chan_b_samples;
   assign chan[2] = chan_c_samples;
   assign chan[3] = chan_d_samples;

   assign sel_octets = frame_octets(link_format_select);
   assign sel_lanes = frame_lanes(link_format_select);
   // Zero octets marks a code with no layout here
   assign served = sel_octets != OCTETS_RESET;
   // Ready is registered, so it can still be high for the old code when the select moves
   // to an unserved one; served gates the take so no empty frame is ever started
   assign accept = frame_valid && frame_ready && served;
   // Shift only while a frame is on the lanes, so idle lanes hold zero
   assign shift_on = remaining != OCTETS_RESET;

   // Frame layout per format; every bit not named below stays zero
   always_comb begin
      pack48 = '0;
      for (int l = 0; l < NUM_LANES; l++) begin
         lane_word[l] = '0;
      end
      case (link_format_select)
         // One 8-bit sample 0 per lane, one octet per frame
         FMT_8B_4L_8B10B, FMT_8B_4L_64B66B: begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
               lane_word[c] = {chan[c][7:0], 32'h0000_0000};
            end
         end
         // Four 10-bit samples of one channel fill five octets
         FMT_10B_4L_8B10B: begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
               lane_word[c] = {chan[c][9:0], chan[c][21:12], chan[c][33:24], chan[c][45:36]};
            end
         end
         // Four 12-bit samples as one 48-bit run, cut 16 bits per lane
         FMT_12B_3L_64B66B: begin
            pack48 = {chan[0][11:0], chan[1][11:0], chan[2][11:0], chan[3][11:0]};
            for (int l = 0; l < 3; l++) begin
               lane_word[l] = {pack48[47-16*l -: 16], 24'h00_0000};
            end
         end
         // Two 8-bit samples per lane
         FMT_8B_2L_64B66B: begin
            lane_word[0] = {chan[0][7:0], chan[1][7:0], 24'h00_0000};
            lane_word[1] = {chan[2][7:0], chan[3][7:0], 24'h00_0000};
         end
         // Two channel pairs, each over three lanes
         FMT_12B_6L_64B66B: begin
            // Each channel pair fills a triple of lanes, samples split MSBs first
            for (int g = 0; g < 2; g++) begin
               pack48 = {chan[2*g][11:0], chan[2*g][23:12], chan[2*g+1][11:0], chan[2*g+1][23:12]};
               for (int l = 0; l < 3; l++) begin
                  lane_word[3*g+l] = {pack48[47-16*l -: 16], 24'h00_0000};
               end
            end
         end
         // Two 12-bit samples of one channel in three octets
         FMT_12B_4L_64B66B: begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
               lane_word[c] = {chan[c][11:0], chan[c][23:12], 16'h0000};
            end
         end
         // Samples 0 and 1 of each channel on an even and odd lane
         FMT_8B_8L_8B10B: begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
               for (int k = 0; k < 2; k++) begin
                  lane_word[2*c+k] = {chan[c][12*k+7 -: 8], 32'h0000_0000};
               end
            end
         end
         // Even samples on the even lane, odd samples on the odd lane
         FMT_10B_8L_8B10B: begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
               for (int k = 0; k < 2; k++) begin
                  lane_word[2*c+k] = {chan[c][12*k+9 -: 10], chan[c][12*(k+2)+9 -: 10],
                                      chan[c][12*(k+4)+9 -: 10], chan[c][12*(k+6)+9 -: 10]};
               end
            end
         end
         // No layout: every lane word stays zero
         default: begin
            pack48 = '0;
         end
      endcase
   end

   // Octets left to show, counting the one on the lanes now
   // A take reloads even on the last octet, so back to back frames lose no cycle
   always_comb begin
      next_remaining = remaining;
      if (accept) begin
         next_remaining = sel_octets;
      end else if (remaining != OCTETS_RESET) begin
         next_remaining = remaining - 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         remaining <= OCTETS_RESET;
      end else begin
         remaining <= next_remaining;
      end
   end

   // Ready one cycle early on the last octet so frames run back to back
   // Held low for unserved codes from the cycle after the select moves; served in accept is what refuses their frames
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frame_ready <= 1'b0;
      end else begin
         frame_ready <= served && (next_remaining <= 3'h1);
      end
   end

   // Stream framing flags
   // frame_start marks octet 0, where the receiver restarts its words
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         octet_valid <= 1'b0;
         frame_start <= 1'b0;
      end else begin
         octet_valid <= next_remaining != OCTETS_RESET;
         frame_start <= accept;
      end
   end

   // Lowest lanes only; the rest stay powered down
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lane_enable <= LANE_ENABLE_RESET;
         format_supported <= 1'b0;
      end else begin
         for (int l = 0; l < NUM_LANES; l++) begin
            lane_enable[l] <= l < int'(sel_lanes);
         end
         format_supported <= served;
      end
   end

   // One shifter per lane; top octet leaves first, so samples go MSB first
   // Every lane is built; lane_enable tells the pads which ones to power
   for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      lane_octet_shifter #(
         .WORD_BITS(LANE_WORD_BITS)
      ) u_shift (
         .clk(clk),
         .rstn(rstn),
         .load(accept),
         .shift(shift_on),
         .word_in(lane_word[l]),
         .octet_out(lane_octets[OCTET_BITS*l +: OCTET_BITS])
      );
   end
endmodule // adc_lane_frame_mapper

// ==== lane_receiver.sv ====
// Purpose: Far-end model that rebuilds each lane's frame word
// Assumes: Octets arrive on clk while octet_valid is high
// Notes: Unenabled lanes are not written, so their words stay zero from the next frame_start
`timescale 1ns/100ps
module lane_receiver
   import lane_map_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic octet_valid,
   input wire logic frame_start,
   input wire logic [NUM_LANES-1:0] lane_enable,
   input wire logic [OCTET_BITS*NUM_LANES-1:0] lane_octets,
   output logic [LANE_WORD_BITS-1:0] lane_word [NUM_LANES]
);
   logic [3:0] idx;
   // Octet k of a frame lands k octets below the top of the word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idx <= 4'h0;
         for (int l = 0; l < NUM_LANES; l++) lane_word[l] <= '0;
      end else if (octet_valid) begin
         idx <= frame_start ? 4'h1 : idx + 4'h1;
         for (int l = 0; l < NUM_LANES; l++) begin
            if (frame_start) lane_word[l] <= '0;
            if (lane_enable[l]) lane_word[l][39-8*(frame_start ? 0 : idx)-:8] <= lane_octets[8*l+:8];
         end
      end
   end
endmodule // lane_receiver

// ==== adc_lane_frame_mapper_chk.sv ====
// Purpose: Port checks for the lane frame mapper
// Assumes: One clk domain, rstn async low
// Notes: Lane masks come from a local table
`timescale 1ns/100ps
module adc_lane_frame_mapper_chk
   import lane_map_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] link_format_select,
   input wire logic frame_valid,
   input wire logic frame_ready,
   input wire logic format_supported,
   input wire logic [NUM_LANES-1:0] lane_enable,
   input wire logic octet_valid,
   input wire logic frame_start,
   input wire logic [OCTET_BITS*NUM_LANES-1:0] lane_octets
);
   logic [NUM_LANES-1:0] exp_mask;
   logic take;
   logic [3:0] s;
   logic served;
   // Only codes 2 to 10 have a layout; a stale ready never takes a frame for others
   assign served = (s >= 4'h2) && (s <= 4'hA);
   assign take = frame_valid && frame_ready && served;
   assign s = link_format_select;
   // Lane mask trails the select by one cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) exp_mask <= 8'h00;
      else case (s)
         4'h5: exp_mask <= 8'h03;
         4'h4: exp_mask <= 8'h07;
         4'h2, 4'h3, 4'h7, 4'h8: exp_mask <= 8'h0F;
         4'h6: exp_mask <= 8'h3F;
         4'h9, 4'hA: exp_mask <= 8'hFF;
         default: exp_mask <= 8'h00;
      endcase
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_answer; take |=> frame_start && octet_valid; endproperty
   a_answer: assert property (p_answer) else $error("no octet after take");
   property p_start; frame_start |-> octet_valid; endproperty
   a_start: assert property (p_start) else $error("start without octet");
   property p_idle; !octet_valid |-> lane_octets == 64'h0; endproperty
   a_idle: assert property (p_idle) else $error("idle lanes not zero");
   property p_mask; lane_enable == exp_mask; endproperty
   a_mask: assert property (p_mask) else $error("lane enable wrong");
   property p_one; take && (s == 4'h2 || s == 4'h7 || s == 4'h9) |=> ##1 (!octet_valid || frame_start); endproperty
   a_one: assert property (p_one) else $error("single octet frame too long");
   property p_five; take && (s == 4'h3 || s == 4'hA) |=> frame_start ##1 (octet_valid && !frame_start) [*4]; endproperty
   a_five: assert property (p_five) else $error("five octet frame broken");
   property p_ready8; take && s == 4'h8 |=> !frame_ready [*2] ##1 frame_ready; endproperty
   a_ready8: assert property (p_ready8) else $error("ready timing wrong");
   property p_ready1; frame_ready && s == 4'h9 && $stable(s) |=> frame_ready; endproperty
   a_ready1: assert property (p_ready1) else $error("ready dropped");
   c_take: cover property (take);
   c_ten: cover property (take && s == 4'hA);
   c_b2b: cover property (frame_start && $past(octet_valid));
endmodule // adc_lane_frame_mapper_chk

// ==== adc_lane_frame_mapper_test.sv ====
// Purpose: Drives every served format and checks lane words
// Assumes: Samples held steady, so back to back frames match
// Notes: Expected words built from local format tables
`timescale 1ns/100ps
module adc_lane_frame_mapper_test import lane_map_pkg::*; ;
   logic clk, rstn, frame_valid, frame_ready, format_supported, octet_valid, frame_start;
   logic [3:0] link_format_select;
   logic [CHANNEL_BUS_BITS-1:0] chan [4];
   logic [NUM_LANES-1:0] lane_enable;
   logic [OCTET_BITS*NUM_LANES-1:0] lane_octets;
   logic [LANE_WORD_BITS-1:0] lane_word [NUM_LANES];
   int fails, compares, octs;
   // Width, samples per channel, octets, lanes, per code
   int wt[11] = '{0, 0, 8, 10, 12, 8, 12, 8, 12, 8, 10};
   int st[11] = '{0, 0, 1, 4, 1, 1, 2, 1, 2, 2, 8};
   int ft[11] = '{0, 0, 1, 5, 2, 2, 2, 1, 3, 1, 5};
   int lt[11] = '{0, 0, 4, 4, 3, 2, 6, 4, 4, 8, 8};
   adc_lane_frame_mapper i_adc_lane_frame_mapper (.clk(clk), .rstn(rstn), .link_format_select(link_format_select),
      .frame_valid(frame_valid), .chan_a_samples(chan[0]), .chan_b_samples(chan[1]), .chan_c_samples(chan[2]),
      .chan_d_samples(chan[3]), .frame_ready(frame_ready), .format_supported(format_supported),
      .lane_enable(lane_enable), .octet_valid(octet_valid), .frame_start(frame_start), .lane_octets(lane_octets));
   lane_receiver i_lane_receiver (.clk(clk), .rstn(rstn), .octet_valid(octet_valid), .frame_start(frame_start),
      .lane_enable(lane_enable), .lane_octets(lane_octets), .lane_word(lane_word));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Octets counted at the falling edge, away from updates
   always @(negedge clk) if (octet_valid === 1'b1) octs++;
   task automatic chk(logic [63:0] got, logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Lay all samples MSB first in one stream, then cut per lane
   function automatic logic [39:0] exp_lane(int f, int l);
      logic [383:0] s;
      int p, n;
      s = '0;
      p = 383;
      for (int c = 0; c < 4; c++) for (int j = 0; j < st[f]; j++) begin
         n = (f == 10) ? ((j < 4) ? 2 * j : 2 * j - 7) : j;
         for (int b = wt[f] - 1; b >= 0; b--) begin
            s[p] = chan[c][12 * n + b];
            p--;
         end
      end
      return s[383 - 8 * ft[f] * l -: 40] & ~(40'hFF_FFFF_FFFF >> (8 * ft[f]));
   endfunction
   task automatic test_map(logic [3:0] f);
      int k, w;
      @(posedge clk);
      link_format_select <= f;
      repeat (2) @(posedge clk);
      chk(64'(lane_enable), 64'((1 << lt[f]) - 1));
      chk(64'(format_supported), 64'h1);
      octs = 0;
      frame_valid <= 1'b1;
      k = 0;
      w = 0;
      while (k < 2 && w < 20) begin
         @(posedge clk);
         w++;
         if (frame_ready === 1'b1) k++;
      end
      frame_valid <= 1'b0;
      repeat (8) @(posedge clk);
      chk(64'(octs), 64'(2 * ft[f]));
      for (int l = 0; l < 8; l++) chk(64'(lane_word[l]), 64'(exp_lane(f, l)));
      $display("test_map format %0d done", f);
   endtask
   task automatic test_unserved();
      for (int f = 0; f < 16; f++) if (f < 2 || f > 10) begin
         link_format_select <= 4'(f);
         frame_valid <= 1'b1;
         octs = 0;
         repeat (3) @(posedge clk);
         chk({octs[31:0], 7'h0, frame_ready, 7'h0, format_supported, lane_enable}, 64'h0);
      end
      frame_valid <= 1'b0;
      $display("test_unserved done");
   endtask
   // Reset in the middle of a five-octet frame, then the first edge after release
   task automatic test_reset();
      @(posedge clk);
      link_format_select <= 4'h3;
      frame_valid <= 1'b1;
      repeat (3) @(posedge clk);
      frame_valid <= 1'b0;
      rstn <= 1'b0;
      @(negedge clk);
      chk(lane_octets, 64'h0);
      chk(64'({frame_ready, format_supported, octet_valid, frame_start, lane_enable}), 64'h0);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk(64'(lane_enable), 64'h0F);
      chk(64'({frame_ready, format_supported, octet_valid, frame_start}), 64'hC);
      $display("test_reset done");
   endtask
   task automatic finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      frame_valid = 1'b0;
      link_format_select = 4'h0;
      // Within a channel every sample differs in every nibble, so a misplaced nibble shows
      for (int c = 0; c < 4; c++) for (int n = 0; n < 8; n++) chan[c][12 * n +: 12] = 12'h0E8 ^ 12'((c * 8 + n) * 12'h131);
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      for (int f = 2; f < 11; f++) test_map(4'(f));
      test_reset();
      test_map(4'h6);
      test_unserved();
      finish_test();
   end
   // Whole run needs a few hundred cycles
   initial begin
      #20000;
      fails++;
      finish_test();
   end
endmodule // adc_lane_frame_mapper_test
bind adc_lane_frame_mapper adc_lane_frame_mapper_chk i_adc_lane_frame_mapper_chk (.clk(clk), .rstn(rstn),
   .link_format_select(link_format_select), .frame_valid(frame_valid), .frame_ready(frame_ready),
   .format_supported(format_supported), .lane_enable(lane_enable), .octet_valid(octet_valid),
   .frame_start(frame_start), .lane_octets(lane_octets));
